/* inc/gfs_params.svh */
`ifndef GFS_PARAMS_SVH
`define GFS_PARAMS_SVH
// Summary of operation
// - Display button steps readout through fixed cycle
// - Mains readings prefixed P or n by connection
// - Alarm entry shows stop error, else skipped
// - Failed crank attempts latch start failure, block
// - High temperature stops engine without cool-down
// - Oil contact closed while running stops engine
// - Overspeed past delay stops engine after control-on
// - Speed taken from alternator frequency
// - Voltage out of window opens contactor, stops
// - No charge voltage flags charge failure
// - Low battery flags unlatched except off mode
// - Aux inputs act per own action setting
// - Running after 30 s stop raises stop error
// - Mode change keeps engine and contactor state, except off stops a running engine
// - Manual contactor buttons ignored during control-on
// - Manual buttons open mains, close generator
// - Manual stop on load: open, cool, stop
// - Auto mains failure starts, then transfers load
// - Auto mains return transfers back, cools, stops
// - Test runs off load; mains failure goes auto
// - Control-on delay masks all but high temperature and low battery
// - Any enabled running source means started
// - Faults except battery and aux set to action 0 or 3 latch until reset
// APB register offsets
`define GFS_REG_CTRL 12'h000
`define GFS_REG_CRANK 12'h004
`define GFS_REG_LIMITS 12'h008
`define GFS_REG_DELAYS 12'h00c
`define GFS_REG_MEAS 12'h010
`define GFS_REG_STATUS 12'h014
`define GFS_REG_DISP 12'h018
// Reset values
`define GFS_CTRL_RST 32'h0000_0007
`define GFS_CRANK_RST 32'h0000_0305
`define GFS_LIMITS_RST 32'h0000_0000
`define GFS_DELAYS_RST 32'h0000_0000
// Timing: tick of 100 ms, stop watch 30 s
`define GFS_CLK_HZ 10000000
`define GFS_TICK_MS 100
`define GFS_TICK_CYC (`GFS_CLK_HZ / 1000 * `GFS_TICK_MS)
`define GFS_STOP_WATCH_S 30
`define GFS_STOP_WATCH_TICKS (`GFS_STOP_WATCH_S * 1000 / `GFS_TICK_MS)
`endif

/* inc/gfs_pkg.sv */
package gfs_pkg;
	typedef enum logic [1:0] {
		GFS_MODE_OFF = 2'h0,
		GFS_MODE_MAN = 2'h1,
		GFS_MODE_AUTO = 2'h3,
		GFS_MODE_TEST = 2'h2
	} gfs_mode_t;
	// Gray order along start, run, cool, stop
	typedef enum logic [2:0] {
		GFS_ST_IDLE = 3'h0,
		GFS_ST_CRANK = 3'h1,
		GFS_ST_REST = 3'h3,
		GFS_ST_CTRLON = 3'h2,
		GFS_ST_RUN = 3'h6,
		GFS_ST_COOL = 3'h7,
		GFS_ST_STOP = 3'h5
	} gfs_eng_t;
	typedef enum logic [2:0] {
		GFS_DSP_MAINS_A = 3'h0,
		GFS_DSP_MAINS_B = 3'h1,
		GFS_DSP_MAINS_C = 3'h3,
		GFS_DSP_GEN_V = 3'h2,
		GFS_DSP_GEN_F = 3'h6,
		GFS_DSP_BATT = 3'h7,
		GFS_DSP_ALARM = 3'h5
	} gfs_disp_t;
endpackage

/* design/gfs_supervisor.sv */
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "gfs_params.svh"
module gfs_supervisor #(
	parameter int TICK_CYC = `GFS_TICK_CYC,
	parameter int STOP_TICKS = `GFS_STOP_WATCH_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic btn_display,
	input wire logic btn_reset,
	input wire logic btn_start,
	input wire logic btn_stop,
	input wire logic btn_mains_open,
	input wire logic btn_gen_close,
	input wire logic [1:0] mode_sel,
	input wire logic mode_sel_valid,
	input wire logic mains_ok,
	input wire logic high_temp_sw,
	input wire logic oil_contact_closed,
	input wire logic charge_volt_present,
	input wire logic aux_input_one,
	input wire logic aux_input_two,
	output logic start_out,
	output logic fuel_out,
	output logic horn_out,
	output logic mains_contactor,
	output logic gen_contactor,
	output logic [1:0] mode_out,
	output logic [10:0] fault_led,
	output logic [2:0] disp_sel,
	output logic disp_prefix_n
);
	import gfs_pkg::*;
	// Divider is 24 bits and stop watch 16 bits, so refuse larger counts
	if (TICK_CYC < 1 || TICK_CYC > 16777216 || STOP_TICKS < 1 ||
		STOP_TICKS > 65535) begin : g_bad_timing
		$error("gfs_supervisor: bad timing parameters");
	end
	// Fault indices
	localparam int F_START = 0, F_TEMP = 1, F_OIL = 2, F_SPEED = 3;
	localparam int F_VOLT = 4, F_CHG = 5, F_BATT = 6, F_AUX1 = 7;
	localparam int F_AUX2 = 8, F_STOPE = 9, F_NONE = 10;

	// Software registers
	logic [31:0] ctrl_q, ctrl_d, crank_q, crank_d, lim_q, lim_d;
	logic [31:0] dly_q, dly_d, meas_q, meas_d;
	logic wr_acc;
	assign wr_acc = psel & penable & pwrite;
	always_comb begin
		ctrl_d = ctrl_q;
		crank_d = crank_q;
		lim_d = lim_q;
		dly_d = dly_q;
		meas_d = meas_q;
		if (wr_acc) begin
			case (paddr)
			`GFS_REG_CTRL: ctrl_d = pwdata;
			`GFS_REG_CRANK: crank_d = pwdata;
			`GFS_REG_LIMITS: lim_d = pwdata;
			`GFS_REG_DELAYS: dly_d = pwdata;
			`GFS_REG_MEAS: meas_d = pwdata;
			default: ;
			endcase
		end
	end
	// ctrl: [3:0] running_source_select, [4] three phase,
	// [7:5] aux_input_one_action, [10:8] aux_input_two_action
	wire [3:0] running_source_select = ctrl_q[3:0];
	wire three_phase = ctrl_q[4];
	wire [2:0] aux_input_one_action = ctrl_q[7:5];
	wire [2:0] aux_input_two_action = ctrl_q[10:8];
	// crank: [3:0] attempts, [15:8] duration ticks, [23:16] cool ticks
	wire [3:0] start_attempt_count = crank_q[3:0];
	wire [7:0] crank_attempt_duration = crank_q[15:8];
	wire [7:0] cool_down_ticks = crank_q[23:16];
	// limits: speed hz, alt lower, alt upper, battery (8 bits each)
	wire [7:0] speed_upper_limit = lim_q[7:0];
	wire [7:0] alt_voltage_lower_limit = lim_q[15:8];
	wire [7:0] alt_voltage_upper_limit = lim_q[23:16];
	wire [7:0] battery_low_limit = lim_q[31:24];
	wire [7:0] control_on_delay = dly_q[7:0];
	wire [7:0] speed_fault_delay = dly_q[15:8];
	wire [7:0] alt_voltage_fault_delay = dly_q[23:16];
	// meas: alternator frequency, alternator volts, battery tenths
	wire [7:0] gen_freq = meas_q[7:0];
	wire [7:0] gen_volt = meas_q[15:8];
	wire [7:0] batt_volt = meas_q[23:16];

	// Common timebase tick
	logic [23:0] div_q, div_d;
	logic tick;
	always_comb begin
		tick = (div_q == 24'(TICK_CYC - 1));
		div_d = tick ? 24'h0 : div_q + 24'h1;
	end

	// Engine sequencer
	gfs_eng_t eng_q, eng_d;
	gfs_mode_t mode_q, mode_d;
	logic [15:0] tmr_q, tmr_d, stopw_q, stopw_d;
	logic [7:0] spd_q, spd_d, vlt_q, vlt_d;
	logic [3:0] try_q, try_d;
	logic [10:0] flt_q, flt_d;
	logic mc_q, mc_d, gc_q, gc_d, watch_q, watch_d;
	logic running, ctrl_on, latched, trip_stop, trip_open;
	logic aux1_hit, aux2_hit, eng_on;
	always_comb begin
		running = |(running_source_select &
			{~oil_contact_closed, gen_volt != 8'h0,
			gen_freq != 8'h0, ~charge_volt_present});
		eng_on = (eng_q == GFS_ST_RUN) || (eng_q == GFS_ST_COOL) ||
			(eng_q == GFS_ST_CTRLON);
		ctrl_on = (eng_q == GFS_ST_RUN) || (eng_q == GFS_ST_COOL);
		// Aux inputs masked while speed and voltage settle
		aux1_hit = aux_input_one && eng_q != GFS_ST_CTRLON &&
			(aux_input_one_action < 3'h3 || eng_on);
		aux2_hit = aux_input_two && eng_q != GFS_ST_CTRLON &&
			(aux_input_two_action < 3'h3 || eng_on);
		latched = |(flt_q & ~(11'h1 << F_BATT));
		flt_d = flt_q;
		// Set wins over reset
		if (btn_reset)
			flt_d = 11'h0;
		if (high_temp_sw && eng_on)
			flt_d[F_TEMP] = 1'b1;
		if (ctrl_on && oil_contact_closed)
			flt_d[F_OIL] = 1'b1;
		if (ctrl_on && spd_q >= speed_fault_delay && tick)
			flt_d[F_SPEED] = 1'b1;
		if (ctrl_on && vlt_q >= alt_voltage_fault_delay && tick)
			flt_d[F_VOLT] = 1'b1;
		if (ctrl_on && !charge_volt_present)
			flt_d[F_CHG] = 1'b1;
		flt_d[F_BATT] = (mode_q != GFS_MODE_OFF) &&
			(batt_volt < battery_low_limit);
		if (aux1_hit)
			flt_d[F_AUX1] = 1'b1;
		else if (aux_input_one_action == 3'h0 ||
			aux_input_one_action == 3'h3)
			flt_d[F_AUX1] = 1'b0;
		if (aux2_hit)
			flt_d[F_AUX2] = 1'b1;
		else if (aux_input_two_action == 3'h0 ||
			aux_input_two_action == 3'h3)
			flt_d[F_AUX2] = 1'b0;
		if (watch_q && tick && stopw_q >= 16'(STOP_TICKS - 1) && running)
			flt_d[F_STOPE] = 1'b1;
		if (eng_q == GFS_ST_REST && try_q >= start_attempt_count &&
			tmr_q == 16'h0)
			flt_d[F_START] = 1'b1;
		trip_stop = flt_q[F_TEMP] | flt_q[F_OIL] | flt_q[F_SPEED] |
			flt_q[F_VOLT] | flt_q[F_START] |
			(flt_q[F_AUX1] && (aux_input_one_action == 3'h2 ||
			aux_input_one_action == 3'h5)) |
			(flt_q[F_AUX2] && (aux_input_two_action == 3'h2 ||
			aux_input_two_action == 3'h5));
		trip_open = flt_q[F_VOLT] |
			(flt_q[F_AUX1] && aux_input_one_action == 3'h6) |
			(flt_q[F_AUX2] && aux_input_two_action == 3'h6);
	end
	// Mode, contactors and engine sequence
	always_comb begin
		eng_d = eng_q;
		mode_d = mode_q;
		mc_d = mc_q;
		gc_d = gc_q;
		try_d = try_q;
		tmr_d = (tick && tmr_q != 16'h0) ? tmr_q - 16'h1 : tmr_q;
		spd_d = spd_q;
		vlt_d = vlt_q;
		watch_d = watch_q;
		stopw_d = (watch_q && tick) ? stopw_q + 16'h1 : stopw_q;
		if (mode_sel_valid)
			mode_d = gfs_mode_t'(mode_sel);
		if (mode_q == GFS_MODE_TEST && !mains_ok)
			mode_d = GFS_MODE_AUTO;
		// Windowed delay counters
		if (!ctrl_on || gen_freq <= speed_upper_limit)
			spd_d = 8'h0;
		else if (tick && spd_q != 8'hff)
			spd_d = spd_q + 8'h1;
		if (!ctrl_on || (gen_volt >= alt_voltage_lower_limit &&
			gen_volt <= alt_voltage_upper_limit))
			vlt_d = 8'h0;
		else if (tick && vlt_q != 8'hff)
			vlt_d = vlt_q + 8'h1;
		if (trip_open)
			gc_d = 1'b0;
		if (trip_stop && eng_q != GFS_ST_IDLE && eng_q != GFS_ST_STOP) begin
			eng_d = GFS_ST_STOP;
			gc_d = 1'b0;
			watch_d = 1'b1;
			stopw_d = 16'h0;
		end else begin
			case (eng_q)
			GFS_ST_IDLE: begin
				try_d = 4'h0;
				if (!latched && ((mode_q == GFS_MODE_MAN && btn_start) ||
					mode_q == GFS_MODE_TEST ||
					(mode_q == GFS_MODE_AUTO && !mains_ok))) begin
					eng_d = GFS_ST_CRANK;
					tmr_d = 16'(crank_attempt_duration);
				end
			end
			GFS_ST_CRANK: begin
				if (running) begin
					eng_d = GFS_ST_CTRLON;
					tmr_d = 16'(control_on_delay);
				end else if (tmr_q == 16'h0) begin
					eng_d = GFS_ST_REST;
					try_d = try_q + 4'h1;
					tmr_d = 16'({crank_attempt_duration, 1'b0});
				end
			end
			GFS_ST_REST: begin
				if (tmr_q == 16'h0 && try_q < start_attempt_count) begin
					eng_d = GFS_ST_CRANK;
					tmr_d = 16'(crank_attempt_duration);
				end
			end
			GFS_ST_CTRLON: begin
				if (tmr_q == 16'h0)
					eng_d = GFS_ST_RUN;
			end
			GFS_ST_RUN: begin
				if (mode_q == GFS_MODE_MAN) begin
					if (btn_mains_open)
						mc_d = 1'b0;
					if (btn_gen_close && !mc_q)
						gc_d = 1'b1;
				end
				if (mode_q == GFS_MODE_AUTO && !mains_ok) begin
					mc_d = 1'b0;
					gc_d = !mc_q;
				end
				if ((mode_q == GFS_MODE_AUTO && mains_ok) ||
					(mode_q == GFS_MODE_MAN && btn_stop)) begin
					gc_d = 1'b0;
					mc_d = gc_q ? 1'b0 : mains_ok;
					if (!gc_q) begin
						eng_d = GFS_ST_COOL;
						tmr_d = 16'(cool_down_ticks);
					end
				end
				if (mode_q == GFS_MODE_OFF) begin
					eng_d = GFS_ST_STOP;
					watch_d = 1'b1;
					stopw_d = 16'h0;
				end
			end
			GFS_ST_COOL: begin
				if (mode_q == GFS_MODE_AUTO && !mains_ok)
					eng_d = GFS_ST_RUN;
				else if (tmr_q == 16'h0) begin
					eng_d = GFS_ST_STOP;
					watch_d = 1'b1;
					stopw_d = 16'h0;
				end
			end
			GFS_ST_STOP: begin
				if (!gc_q && mains_ok)
					mc_d = 1'b1;
				if (!running || flt_q[F_STOPE]) begin
					eng_d = GFS_ST_IDLE;
					watch_d = 1'b0;
				end
			end
			default: eng_d = GFS_ST_IDLE;
			endcase
		end
	end

	// Readout cycling, with alarm entry skipped when no stop error
	gfs_disp_t dsp_q, dsp_d;
	logic btn_disp_q;
	always_comb begin
		dsp_d = dsp_q;
		if (btn_display && !btn_disp_q) begin
			case (dsp_q)
			GFS_DSP_MAINS_A: dsp_d = GFS_DSP_MAINS_B;
			GFS_DSP_MAINS_B: dsp_d = GFS_DSP_MAINS_C;
			GFS_DSP_MAINS_C: dsp_d = GFS_DSP_GEN_V;
			GFS_DSP_GEN_V: dsp_d = GFS_DSP_GEN_F;
			GFS_DSP_GEN_F: dsp_d = GFS_DSP_BATT;
			GFS_DSP_BATT: dsp_d = flt_q[F_STOPE] ?
				GFS_DSP_ALARM : GFS_DSP_MAINS_A;
			default: dsp_d = GFS_DSP_MAINS_A;
			endcase
		end
	end

	// Flashing and horn
	logic [2:0] blink_q;
	logic [10:0] led_d;
	always_comb begin
		led_d = blink_q[2] ? flt_q : 11'h0;
		led_d[F_NONE] = 1'b0;
	end

	// Registered state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `GFS_CTRL_RST;
			crank_q <= `GFS_CRANK_RST;
			lim_q <= `GFS_LIMITS_RST;
			dly_q <= `GFS_DELAYS_RST;
			meas_q <= 32'h0;
			div_q <= 24'h0;
			eng_q <= GFS_ST_IDLE;
			mode_q <= GFS_MODE_OFF;
			tmr_q <= 16'h0;
			stopw_q <= 16'h0;
			spd_q <= 8'h0;
			vlt_q <= 8'h0;
			try_q <= 4'h0;
			flt_q <= 11'h0;
			mc_q <= 1'b1;
			gc_q <= 1'b0;
			watch_q <= 1'b0;
			dsp_q <= GFS_DSP_MAINS_A;
			btn_disp_q <= 1'b0;
			blink_q <= 3'h0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			start_out <= 1'b0;
			fuel_out <= 1'b0;
			horn_out <= 1'b0;
			mains_contactor <= 1'b0;
			gen_contactor <= 1'b0;
			mode_out <= 2'h0;
			fault_led <= 11'h0;
			disp_sel <= 3'h0;
			disp_prefix_n <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			crank_q <= crank_d;
			lim_q <= lim_d;
			dly_q <= dly_d;
			meas_q <= meas_d;
			div_q <= div_d;
			eng_q <= eng_d;
			mode_q <= mode_d;
			tmr_q <= tmr_d;
			stopw_q <= stopw_d;
			spd_q <= spd_d;
			vlt_q <= vlt_d;
			try_q <= try_d;
			flt_q <= flt_d;
			mc_q <= mc_d;
			gc_q <= gc_d;
			watch_q <= watch_d;
			dsp_q <= dsp_d;
			btn_disp_q <= btn_display;
			if (tick)
				blink_q <= blink_q + 3'h1;
			// Zero-wait APB, unmapped reads zero, with error only above the display register
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > `GFS_REG_DISP);
			case (paddr)
			`GFS_REG_CTRL: prdata <= ctrl_q;
			`GFS_REG_CRANK: prdata <= crank_q;
			`GFS_REG_LIMITS: prdata <= lim_q;
			`GFS_REG_DELAYS: prdata <= dly_q;
			`GFS_REG_MEAS: prdata <= meas_q;
			`GFS_REG_STATUS: prdata <= {8'h0, 1'b0, eng_q, mode_q,
				mc_q, gc_q, 5'h0, flt_q};
			`GFS_REG_DISP: prdata <= {28'h0, 1'b0, dsp_q};
			default: prdata <= 32'h0;
			endcase
			start_out <= (eng_q == GFS_ST_CRANK);
			fuel_out <= eng_on || eng_q == GFS_ST_CRANK;
			horn_out <= |flt_q[F_STOPE-1:0];
			mains_contactor <= mc_q;
			gen_contactor <= gc_q;
			mode_out <= mode_q;
			fault_led <= led_d;
			disp_sel <= dsp_q;
			disp_prefix_n <= !three_phase;
		end
	end

	chk_stop_no_cool: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(flt_q[F_TEMP]) && eng_q == GFS_ST_RUN |=> eng_q == GFS_ST_STOP)
		else $error("temperature fault did not stop");
	chk_alarm_skip: assert property (@(posedge pclk) disable iff (!presetn)
		dsp_q == GFS_DSP_BATT && btn_display && !btn_disp_q &&
		!flt_q[F_STOPE] |=> dsp_q == GFS_DSP_MAINS_A)
		else $error("alarm entry not skipped");
	chk_battery_clears: assert property (@(posedge pclk)
		disable iff (!presetn)
		batt_volt >= battery_low_limit |=> !flt_q[F_BATT])
		else $error("battery flag stuck");
	chk_fault_latch: assert property (@(posedge pclk) disable iff (!presetn)
		!btn_reset |=>
		(flt_q[5:0] & $past(flt_q[5:0])) == $past(flt_q[5:0]))
		else $error("fault lost without reset");
	chk_test_to_auto: assert property (@(posedge pclk)
		disable iff (!presetn)
		mode_q == GFS_MODE_TEST && !mains_ok && !mode_sel_valid
		|=> mode_q == GFS_MODE_AUTO)
		else $error("test mode kept on mains loss");
	chk_ctrlon_ignore: assert property (@(posedge pclk)
		disable iff (!presetn)
		eng_q == GFS_ST_CTRLON && !trip_stop |=> $stable(gc_q))
		else $error("contactor moved in control-on");
	chk_volt_opens: assert property (@(posedge pclk) disable iff (!presetn)
		flt_q[F_VOLT] |=> !gc_q)
		else $error("contactor kept closed");
	chk_crank_start: assert property (@(posedge pclk) disable iff (!presetn)
		eng_q == GFS_ST_CRANK && running && !trip_stop
		|=> eng_q == GFS_ST_CTRLON)
		else $error("start not detected");
endmodule // gfs_supervisor

/* bench/gfs_engine_model.sv */
`timescale 1ns/1ps
module gfs_engine_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start_out,
	input wire logic fuel_out,
	input wire logic will_start,
	input wire logic stuck,
	input wire logic chg_cut,
	output logic oil_contact_closed,
	output logic charge_volt_present
);
	logic run_q, run_d;
	logic [1:0] crank_q, crank_d;
	// Catches after three crank cycles; a stuck engine ignores fuel cut
	always_comb begin
		crank_d = 2'h0;
		if (start_out && will_start && crank_q != 2'h3)
			crank_d = crank_q + 2'h1;
		run_d = run_q;
		if (crank_q == 2'h3)
			run_d = 1'b1;
		if (!fuel_out && !stuck)
			run_d = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
			crank_q <= 2'h0;
		end else begin
			run_q <= run_d;
			crank_q <= crank_d;
		end
	end
	// No oil pressure at rest, so the contact stays closed
	assign oil_contact_closed = !run_q;
	assign charge_volt_present = run_q && !chg_cut;
endmodule // gfs_engine_model

/* bench/test_gfs_supervisor.sv */
`timescale 1ns/1ps
`include "gfs_params.svh"
module test_gfs_supervisor;
	import gfs_pkg::*;
	localparam int TK = 10;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, st_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, meas;
	logic [5:0] btn;
	logic [1:0] msel, mode_out;
	logic mval, mains_ok, hot, aux1, aux2, oil, chg, will, stuck, cut;
	logic start_out, fuel_out, horn_out, m_con, g_con, pfx_n;
	logic [10:0] fault_led;
	logic [2:0] disp_sel;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int n, cranks;
	gfs_disp_t dq[$];

	gfs_supervisor #(.TICK_CYC(TK), .STOP_TICKS(5)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .btn_display(btn[0]),
		.btn_reset(btn[1]), .btn_start(btn[2]), .btn_stop(btn[3]),
		.btn_mains_open(btn[4]), .btn_gen_close(btn[5]), .mode_sel(msel),
		.mode_sel_valid(mval), .mains_ok(mains_ok), .high_temp_sw(hot),
		.oil_contact_closed(oil), .charge_volt_present(chg),
		.aux_input_one(aux1), .aux_input_two(aux2), .start_out(start_out),
		.fuel_out(fuel_out), .horn_out(horn_out), .mains_contactor(m_con),
		.gen_contactor(g_con), .mode_out(mode_out), .fault_led(fault_led),
		.disp_sel(disp_sel), .disp_prefix_n(pfx_n));
	gfs_engine_model u_eng (.pclk(pclk), .presetn(presetn),
		.start_out(start_out), .fuel_out(fuel_out), .will_start(will),
		.stuck(stuck), .chg_cut(cut), .oil_contact_closed(oil),
		.charge_volt_present(chg));

	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Cycle ceiling and crank attempt counter
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		st_q <= start_out;
		if (start_out && !st_q)
			cranks++;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Request held until pready is seen; one idle edge before the next
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rs();
		repeat (3) @(posedge pclk);
		apb(1'b0, `GFS_REG_STATUS, 32'h0);
	endtask
	task automatic tk(int t);
		repeat (t * TK) @(posedge pclk);
	endtask
	task automatic press(int i);
		btn[i] <= 1'b1;
		repeat (2) @(posedge pclk);
		btn[i] <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic setm(gfs_mode_t m);
		msel <= m;
		mval <= 1'b1;
		@(posedge pclk);
		mval <= 1'b0;
		@(posedge pclk);
	endtask
	// Walk the readout once round, expecting the queue's order
	task automatic show();
		chk("disp", 32'(dq[0]), 32'(disp_sel));
		for (int i = 1; i <= dq.size(); i++) begin
			press(0);
			chk("disp", 32'(dq[i % dq.size()]), 32'(disp_sel));
		end
	endtask
	task automatic run_up();
		for (n = 0; n < 300 && oil !== 1'b0; n++)
			@(posedge pclk);
	endtask
	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, btn, msel, mval} = '0;
		{hot, aux1, aux2, stuck, cut} = '0;
		{mains_ok, will} = 2'h3;
		seed = 32'h3187;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `GFS_REG_CTRL, 32'h0);
		chk("ctrl", `GFS_CTRL_RST, rd);
		apb(1'b0, `GFS_REG_CRANK, 32'h0);
		chk("crank", `GFS_CRANK_RST, rd);
		apb(1'b0, 12'h01c, 32'h0);
		chk("bad_err", 32'h1, 32'(perr));
		chk("bad_rd", 32'h0, rd);
		// Readout cycle with no alarm entry
		dq = '{GFS_DSP_MAINS_A, GFS_DSP_MAINS_B, GFS_DSP_MAINS_C,
			GFS_DSP_GEN_V, GFS_DSP_GEN_F, GFS_DSP_BATT};
		chk("pfx", 32'h1, 32'(pfx_n));
		show();
		apb(1'b1, `GFS_REG_CTRL, 32'h18);
		@(posedge pclk);
		chk("pfx", 32'h0, 32'(pfx_n));
		apb(1'b1, `GFS_REG_CRANK, 32'h0002_0202);
		apb(1'b1, `GFS_REG_DELAYS, 32'h0002_0203);
		meas = {8'h0, 8'h10 + 8'(xs() % 32), 8'h20 + 8'(xs() % 128), 8'h32};
		apb(1'b1, `GFS_REG_MEAS, meas);
		// Low battery: ignored when off, flagged, then clears itself
		apb(1'b1, `GFS_REG_LIMITS, 32'hfff0_1040);
		rs();
		chk("batt_off", 32'h0, 32'(rd[6]));
		setm(GFS_MODE_MAN);
		rs();
		chk("batt_on", 32'h1, 32'(rd[6]));
		chk("horn", 32'h1, 32'(horn_out));
		apb(1'b1, `GFS_REG_LIMITS, 32'h08f0_1040);
		rs();
		chk("batt_clr", 32'h0, 32'(rd[10:0]));
		// Engine that never catches
		will <= 1'b0;
		cranks = 0;
		press(2);
		for (n = 0; n < 600 && horn_out !== 1'b1; n++)
			@(posedge pclk);
		rs();
		chk("cranks", 32'd2, 32'(cranks));
		chk("st_fail", 32'h1, 32'(rd[0]));
		press(2);
		chk("locked", 32'h0, 32'(start_out));
		press(1);
		// Manual run, transfer, charge loss, stop
		will <= 1'b1;
		press(2);
		run_up();
		press(4);
		chk("crank_off", 32'h0, 32'(start_out));
		chk("ign_open", 32'h1, 32'(m_con));
		tk(4);
		press(4);
		press(5);
		rs();
		chk("contactors", 32'h1, 32'(rd[17:16]));
		cut <= 1'b1;
		tk(1);
		rs();
		chk("charge", 32'h1, 32'(rd[5]));
		chk("still_run", 32'h1, 32'(fuel_out));
		cut <= 1'b0;
		press(1);
		press(3);
		chk("cooling", 32'h1, 32'({g_con, fuel_out}));
		for (n = 0; n < 300 && fuel_out !== 1'b0; n++)
			@(posedge pclk);
		chk("cooled", 32'h1, 32'(n >= TK));
		// Overspeed on an engine that will not stop
		press(2);
		run_up();
		tk(4);
		stuck <= 1'b1;
		apb(1'b1, `GFS_REG_MEAS, {meas[31:8], 8'h50});
		for (n = 0; n < 100 && fuel_out !== 1'b0; n++)
			@(posedge pclk);
		chk("os_delay", 32'h1, 32'(n >= TK && n < 4 * TK));
		rs();
		chk("overspeed", 32'h202, 32'({rd[3], rd[9]} + 10'h200));
		tk(7);
		rs();
		chk("stop_err", 32'h1, 32'(rd[9]));
		dq.push_back(GFS_DSP_ALARM);
		show();
		// Auto transfer on mains loss and return
		stuck <= 1'b0;
		apb(1'b1, `GFS_REG_MEAS, meas);
		press(1);
		mains_ok <= 1'b0;
		setm(GFS_MODE_AUTO);
		for (n = 0; n < 600 && g_con !== 1'b1; n++)
			@(posedge pclk);
		chk("to_gen", 32'h1, 32'({m_con, g_con}));
		setm(GFS_MODE_MAN);
		chk("keep", 32'h3, 32'({g_con, fuel_out}));
		setm(GFS_MODE_AUTO);
		mains_ok <= 1'b1;
		for (n = 0; n < 600 && fuel_out !== 1'b0; n++)
			@(posedge pclk);
		chk("back", 32'h4, 32'({m_con, g_con, fuel_out}));
		// Test run stays off load until mains fails
		setm(GFS_MODE_TEST);
		run_up();
		tk(4);
		chk("off_load", 32'h2, 32'({m_con, g_con}));
		mains_ok <= 1'b0;
		for (n = 0; n < 600 && g_con !== 1'b1; n++)
			@(posedge pclk);
		chk("test_auto", 32'(GFS_MODE_AUTO), 32'(mode_out));
		// Over-temperature trips at once and stays latched
		hot <= 1'b1;
		for (n = 0; n < 100 && fuel_out !== 1'b0; n++)
			@(posedge pclk);
		chk("hot_stop", 32'h1, 32'(n < 5));
		hot <= 1'b0;
		rs();
		chk("hot_latch", 32'h1, 32'(rd[1]));
		// Indicator lights in its flash phase with only the temperature bit
		for (n = 0; n < 100 && fault_led === 11'h0; n++)
			@(posedge pclk);
		chk("led", 32'h2, 32'(fault_led));
		// Aux inputs: first latched, second unlatched
		apb(1'b1, `GFS_REG_CTRL, 32'h38);
		{aux1, aux2} <= 2'h3;
		rs();
		chk("aux_on", 32'h3, 32'(rd[8:7]));
		{aux1, aux2} <= 2'h0;
		rs();
		chk("aux_off", 32'h1, 32'(rd[8:7]));
		// Alternator voltage out of window drops load and stops after its fault delay
		press(1);
		run_up();
		for (n = 0; n < 600 && g_con !== 1'b1; n++)
			@(posedge pclk);
		apb(1'b1, `GFS_REG_MEAS, {meas[31:16], 8'h0, meas[7:0]});
		for (n = 0; n < 100 && g_con !== 1'b0; n++)
			@(posedge pclk);
		chk("volt_delay", 32'h1, 32'(n >= TK && n < 4 * TK));
		rs();
		chk("volt_flt", 32'h2, 32'({rd[4], fuel_out}));
		conclude();
	end
endmodule // test_gfs_supervisor
